// ==== sim/nibble_sram_model.sv ====
// behavioural clockless 4096 x 4 memory with whole-array wipe
// assumes the bench resolves the shared data wire and feeds it back
module nibble_sram_model (
	input  wire logic [11:0]              word_select_lines_in,
	input  wire sram_ctl_pkg::ctrl_pins_t ctrl_pins_in,
	input  wire logic [3:0]               shared_data_pins_in,
	output logic      [3:0]               shared_data_pins_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mem [4096];
	logic [3:0] last = 4'h0;
	wire  [3:0] val;
	wire sel = !ctrl_pins_in.chip_sel_n;
	wire wr = sel && !ctrl_pins_in.wr_strobe_n;
	wire wipe = sel && !ctrl_pins_in.array_wipe_n;
	wire drv = sel && !ctrl_pins_in.out_en_n && ctrl_pins_in.wr_strobe_n;
	assign #20 val = mem[word_select_lines_in];
	// data shows the inverse of the last read until the select and output enable access times pass
	wire sel_ok;
	wire oe_ok;
	assign #20 sel_ok = sel;
	assign #10 oe_ok = drv;
	always @(negedge wr) mem[word_select_lines_in] = shared_data_pins_in;
	always @(posedge wipe) foreach (mem[i]) mem[i] = 4'h0;
	// released wire shows the inverse, so a stale value never reads back
	always @(negedge drv) last = val;
	assign shared_data_pins_out = (drv && sel_ok && oe_ok) ? val : ~last;
endmodule // nibble_sram_model

// ==== sim/sram_ctl_props.sv ====
// pin timing assertions for the nibble sram controller
// assumes a bind onto sram_ctl; one clock, reset synchronous
module sram_ctl_props #(parameter int ADDR_W = 12) (
	input wire logic                     core_clk_in,
	input wire logic                     reset_in,
	input wire logic [ADDR_W-1:0]        word_select_lines_out,
	input wire sram_ctl_pkg::ctrl_pins_t ctrl_pins_out,
	input wire logic                     shared_data_pins_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	wire cs = ctrl_pins_out.chip_sel_n;
	wire we = ctrl_pins_out.wr_strobe_n;
	wire wp = ctrl_pins_out.array_wipe_n;
	property p_addr; !cs && $past(!cs) |-> $stable(word_select_lines_out); endproperty
	a_addr: assert property (p_addr) else $error("address moved while selected");
	property p_we; $fell(we) |-> !we [*2]; endproperty
	a_we: assert property (p_we) else $error("strobe pulse too short");
	property p_cs; $fell(cs) |-> !cs [*3]; endproperty
	a_cs: assert property (p_cs) else $error("select pulse too short");
	property p_wp; $fell(wp) |-> !wp [*5]; endproperty
	a_wp: assert property (p_wp) else $error("wipe pulse too short");
	property p_wcs; $fell(wp) |-> !cs [*5]; endproperty
	a_wcs: assert property (p_wcs) else $error("select short in wipe");
	property p_wsel; !wp |-> !cs && ctrl_pins_out.out_en_n; endproperty
	a_wsel: assert property (p_wsel) else $error("wipe without select");
	property p_fight; !ctrl_pins_out.out_en_n |-> !shared_data_pins_oe_out; endproperty
	a_fight: assert property (p_fight) else $error("bus driven during read");
	property p_wr; !we |-> !cs && shared_data_pins_oe_out; endproperty
	a_wr: assert property (p_wr) else $error("write without select or data");
endmodule // sram_ctl_props
bind sram_ctl sram_ctl_props #(.ADDR_W(ADDR_W)) sram_ctl_props_inst (.core_clk_in(core_clk_in),
	.reset_in(reset_in), .word_select_lines_out(word_select_lines_out), .ctrl_pins_out(ctrl_pins_out),
	.shared_data_pins_oe_out(shared_data_pins_oe_out));

// ==== sim/tb_sram_ctl.sv ====
// self-checking bench for the nibble sram controller
// assumes the package, controller, model and checker are compiled first
module tb_sram_ctl;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, req_valid_in = 1'b0;
	sram_ctl_pkg::req_t req_in = '0;
	sram_ctl_pkg::ctrl_pins_t ctrl_pins_out;
	logic [11:0] word_select_lines_out;
	logic [3:0]  rsp_data_out, ctl_data, mem_data, bus_data, shadow [4096];
	logic        req_ready_out, rsp_valid_out, data_oe;
	int          err_total = 0, n_compared = 0;
	always #4 core_clk_in = ~core_clk_in;
	assign bus_data = data_oe ? ctl_data : mem_data;
	sram_ctl sram_ctl_inst (.core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .word_select_lines_out(word_select_lines_out),
		.ctrl_pins_out(ctrl_pins_out), .shared_data_pins_in(bus_data), .shared_data_pins_out(ctl_data),
		.shared_data_pins_oe_out(data_oe));
	nibble_sram_model nibble_sram_model_inst (.word_select_lines_in(word_select_lines_out),
		.ctrl_pins_in(ctrl_pins_out), .shared_data_pins_in(bus_data), .shared_data_pins_out(mem_data));
	function automatic logic [3:0] expect_rd(logic [11:0] a);
		return shadow[a];
	endfunction
	task automatic chk(logic [3:0] got, logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// clock enable stalls at random while busy, never at the taking edge
	task automatic op(sram_ctl_pkg::op_t o, logic [11:0] a, logic [3:0] d);
		logic got;
		got = 1'b0;
		@(negedge core_clk_in);
		clk_en_in = 1'b1;
		req_in = '{o, a, d};
		req_valid_in = 1'b1;
		@(negedge core_clk_in);
		req_valid_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		for (int i = 0; i < 200 && !(req_ready_out === 1'b1 && (o != sram_ctl_pkg::OP_READ || got)); i++) begin
			@(negedge core_clk_in);
			clk_en_in = ($urandom % 4) != 0;
			if (rsp_valid_out === 1'b1) got = 1'b1;
		end
		if (o == sram_ctl_pkg::OP_READ) chk(got ? rsp_data_out : 4'hX, expect_rd(a));
		else chk({3'b000, got}, 4'h0);
		// a wait limit that runs out leaves ready low and counts as a mismatch
		chk({3'b000, req_ready_out}, 4'h1);
		if (o == sram_ctl_pkg::OP_WRITE) shadow[a] = d;
		if (o == sram_ctl_pkg::OP_WIPE) foreach (shadow[i]) shadow[i] = 4'h0;
		chk(ctrl_pins_out, 4'hF);
	endtask
	initial begin
		void'($urandom(32'hC26A));
		repeat (20) @(negedge core_clk_in);
		reset_in = 1'b0;
		op(sram_ctl_pkg::OP_WIPE, 12'h000, 4'h0);
		op(sram_ctl_pkg::OP_READ, 12'hFFF, 4'h0);
		op(sram_ctl_pkg::OP_WRITE, 12'hFFF, 4'h5);
		op(sram_ctl_pkg::OP_WRITE, 12'hFFF, 4'hA);
		op(sram_ctl_pkg::OP_READ, 12'hFFF, 4'h0);
		for (int k = 0; k < 40; k++)
			op(sram_ctl_pkg::op_t'($urandom % 3), 12'($urandom % 8 * 12'h249), 4'($urandom));
		stop_test();
	end
	initial begin
		#400000;
		err_total++;
		stop_test();
	end
endmodule // tb_sram_ctl

// ==== verilog/sram_ctl.sv ====
// host-side controller driving an asynchronous 4096 x 4 sram with wipe
// assumes the memory pins sit outside this clock domain; one 125 MHz clock
// assumes a request is taken only while idle; one offered while busy is ignored
// How it works
// - address changes only with select high
// - strobe low at least 16 ns
// - select low at least 18 ns
// - address stable 16 ns before write end
// - wipe cycle and select low 40 ns
// - wipe pulse low at least 38 ns
`include "sram_ctl_regs.svh"

module sram_ctl #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 4
) (
	// clock, reset, enable
	input  wire logic                 core_clk_in,
	input  wire logic                 reset_in,
	input  wire logic                 clk_en_in,
	// request port
	input  wire logic                 req_valid_in,
	input  wire sram_ctl_pkg::req_t   req_in,
	output logic                      req_ready_out,
	output logic                      rsp_valid_out,
	output logic [DATA_W-1:0]         rsp_data_out,
	// memory pins
	output logic [ADDR_W-1:0]         word_select_lines_out,
	output sram_ctl_pkg::ctrl_pins_t  ctrl_pins_out,
	input  wire logic [DATA_W-1:0]    shared_data_pins_in,
	output logic [DATA_W-1:0]         shared_data_pins_out,
	output logic                      shared_data_pins_oe_out
);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	// the pin map and the timing counts are built for one memory shape only
	if (ADDR_W != 12 || DATA_W != 4) begin : g_bad_shape
		$error("sram_ctl serves only a 12-bit address and 4-bit data");
	end

	// ---------------------------------------------------------------
	// pin input synchroniser
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] din_meta_q;
	logic [DATA_W-1:0] din_sync_q;

	// one two-stage chain per data bit; only the second stage feeds logic
	for (genvar b = 0; b < DATA_W; b++) begin : g_din_sync
		always_ff @(posedge core_clk_in) begin
			if (reset_in) begin
				din_meta_q[b] <= 1'b0;
				din_sync_q[b] <= 1'b0;
			end else if (clk_en_in) begin
				din_meta_q[b] <= shared_data_pins_in[b];
				din_sync_q[b] <= din_meta_q[b];
			end
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	sram_ctl_pkg::state_t state_q;
	sram_ctl_pkg::op_t    op_q;
	logic [3:0]           cnt_q;

	// pulse lengths in cycles: a read waits out address access plus one
	// cycle of margin for the input path, a write covers the longer select
	// minimum, a wipe covers its whole cycle; counts round up, so rounding
	// only ever adds margin
	function automatic logic [3:0] phase_len(input sram_ctl_pkg::op_t op);
		case (op)
			sram_ctl_pkg::OP_WRITE: phase_len = 4'(`WRITE_LOW_CYC);
			sram_ctl_pkg::OP_WIPE:  phase_len = 4'(`WIPE_LOW_CYC);
			default:                phase_len = 4'(`READ_WAIT_CYC);
		endcase
	endfunction

	// true in the final cycle of a counted phase; the control pin and bus enable
	// drivers and the ready and read-take logic key off this edge
	function automatic logic phase_last(input sram_ctl_pkg::state_t st,
		input sram_ctl_pkg::state_t want, input logic [3:0] cnt);
		phase_last = (st == want) && (cnt <= 4'h1);
	endfunction

	// the pulse phase counts down; every pin change happens on a state edge
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q <= sram_ctl_pkg::ST_IDLE;
			op_q    <= sram_ctl_pkg::OP_READ;
			cnt_q   <= 4'h0;
		end else if (clk_en_in) begin
			case (state_q)
				sram_ctl_pkg::ST_IDLE: begin
					if (req_valid_in) begin
						op_q    <= req_in.op;
						state_q <= sram_ctl_pkg::ST_SETUP;
					end
				end
				sram_ctl_pkg::ST_SETUP: begin
					// address settled with select high; now assert
					cnt_q   <= phase_len(op_q);
					state_q <= sram_ctl_pkg::ST_PULSE;
				end
				sram_ctl_pkg::ST_PULSE: begin
					if (cnt_q > 4'h1)
						cnt_q <= cnt_q - 4'h1;
					else
						state_q <= sram_ctl_pkg::ST_SAMPLE;
				end
				sram_ctl_pkg::ST_SAMPLE: begin
					// three recovery cycles let the synchronised data arrive
					cnt_q   <= 4'(`RECOVER_CYC);
					state_q <= sram_ctl_pkg::ST_RECOV;
				end
				sram_ctl_pkg::ST_RECOV: begin
					if (cnt_q > 4'h1)
						cnt_q <= cnt_q - 4'h1;
					else
						state_q <= sram_ctl_pkg::ST_IDLE;
				end
				default: state_q <= sram_ctl_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	// decoded levels of the four control pins while a cycle is asserted
	function automatic sram_ctl_pkg::ctrl_pins_t pins_for_op(input sram_ctl_pkg::op_t op);
		sram_ctl_pkg::ctrl_pins_t p;
		p.chip_sel_n   = 1'b0;
		p.out_en_n     = (op != sram_ctl_pkg::OP_READ);
		p.wr_strobe_n  = (op != sram_ctl_pkg::OP_WRITE);
		p.array_wipe_n = (op != sram_ctl_pkg::OP_WIPE);
		return p;
	endfunction

	// address and write data move only while every strobe is high
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			word_select_lines_out <= 12'h000;
			shared_data_pins_out  <= 4'h0;
		end else if (clk_en_in) begin
			if (state_q == sram_ctl_pkg::ST_IDLE && req_valid_in) begin
				word_select_lines_out <= req_in.addr;
				shared_data_pins_out  <= req_in.wdata;
			end
		end
	end

	// select, strobe and wipe fall together and rise together, so each one
	// meets its own minimum low time whichever of them ends the cycle
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ctrl_pins_out <= 4'hF;
		end else if (clk_en_in) begin
			if (state_q == sram_ctl_pkg::ST_SETUP)
				ctrl_pins_out <= pins_for_op(op_q);
			else if (phase_last(state_q, sram_ctl_pkg::ST_PULSE, cnt_q))
				ctrl_pins_out <= 4'hF;
		end
	end

	// the bus is driven only for writes, from the address phase to the end
	// of recovery; that covers data hold past the strobe rise, and the memory
	// never drives then because its output enable stays high
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			shared_data_pins_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			if (state_q == sram_ctl_pkg::ST_IDLE && req_valid_in)
				shared_data_pins_oe_out <= (req_in.op == sram_ctl_pkg::OP_WRITE);
			else if (phase_last(state_q, sram_ctl_pkg::ST_RECOV, cnt_q))
				shared_data_pins_oe_out <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// request and response
	// ---------------------------------------------------------------
	logic [1:0] rd_pipe_q;
	logic       req_ready_d;
	logic       rd_take_d;

	always_comb begin
		req_ready_d = phase_last(state_q, sram_ctl_pkg::ST_RECOV, cnt_q) ||
			(state_q == sram_ctl_pkg::ST_IDLE && !req_valid_in);
		// the edge that raises the pins also loads the first synchroniser
		// stage, while select and output enable are still low
		rd_take_d   = phase_last(state_q, sram_ctl_pkg::ST_PULSE, cnt_q) && (op_q == sram_ctl_pkg::OP_READ);
	end

	// two stages of delay match the synchroniser, so the response picks up
	// exactly the nibble seen on the final pulse edge
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out  <= 4'h0;
			rd_pipe_q     <= 2'b00;
		end else if (clk_en_in) begin
			req_ready_out <= req_ready_d;
			rd_pipe_q     <= {rd_pipe_q[0], rd_take_d};
			rsp_valid_out <= rd_pipe_q[1];
			if (rd_pipe_q[1])
				rsp_data_out <= din_sync_q;
		end
	end

endmodule // sram_ctl

// ==== verilog/sram_ctl_pkg.sv ====
// types for the nibble sram controller
// assumes sram_ctl_regs.svh supplies the timing counts
package sram_ctl_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b011,
		ST_SAMPLE = 3'b010,
		ST_RECOV = 3'b110
	} state_t;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_WIPE  = 2'h2
	} op_t;

	typedef struct packed {
		op_t         op;
		logic [11:0] addr;
		logic [3:0]  wdata;
	} req_t;

	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic wr_strobe_n;
		logic array_wipe_n;
	} ctrl_pins_t;

endpackage

// ==== verilog/sram_ctl_regs.svh ====
// timing constants for the nibble sram controller
// assumes a 125 MHz core clock; times in ns, counts in cycles
`ifndef SRAM_CTL_REGS_SVH
`define SRAM_CTL_REGS_SVH

`define CLK_PERIOD_NS           8
`define ADDRESS_TO_DATA_DELAY_NS 20
`define OE_TO_DATA_NS           10
`define CYCLE_MIN_NS            20
`define STROBE_TO_FLOAT_DELAY_NS 8
`define STROBE_LOW_MIN_NS       16
`define SELECT_LOW_MIN_NS       18
`define ADDR_TO_END_MIN_NS      16
`define WIPE_CYCLE_MIN_NS       40
`define WIPE_PULSE_MIN_NS       38
`define DATA_HOLD_CLEAR_NS      5

// least times round up
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC  `NS_TO_CYC(`ADDRESS_TO_DATA_DELAY_NS + `CLK_PERIOD_NS)
`define FLOAT_WAIT_CYC `NS_TO_CYC(`STROBE_TO_FLOAT_DELAY_NS)
`define WRITE_LOW_CYC  `NS_TO_CYC(`SELECT_LOW_MIN_NS)
`define WIPE_LOW_CYC   `NS_TO_CYC(`WIPE_CYCLE_MIN_NS)
`define RECOVER_CYC    `NS_TO_CYC(`CYCLE_MIN_NS)

`endif
